//--- hdl/clock_source_control_config_regs.vh
// Offsets, field positions and reset values of the clock source control block
// Functional notes
// - Bit 25 of control reads PLL locked, read-only, zero after reset.
// - Bit 24 enables the PLL; hardware clears it entering deepest standby.
// - Bit 16 enables external oscillator; hardware clears it entering standby.
// - Bit 19 arms monitoring, active only while external oscillator reports ready.
// - Active monitoring plus abnormal external oscillator sets failure flag and NMI.
// - Bit 18 selects external clock over crystal; change only while disabled.
// - Bit 17 reads external ready; falls six oscillator cycles after disable.
// - Bits 15:8 hold factory calibration, loaded automatically at startup.
// - Trim bits 7:3 reset to 16; tuning is calibration plus trim minus 16.
// - Bit 1 internal ready resets to 1, falls six cycles after disable.
// - Bit 0 internal enable resets 1; set on standby return or failure.
// - Output select 26:24 gives nothing when top bit 0, else four sources.
// - Bit 16 of configuration picks PLL input; write only while PLL off.
// - Converter divider ordered 13:11,15:14; codes 000xx..110xx divide 2,4,6,8.
// - Codes 00100..11100 divide 4,8,12,16; others map to 16 up to 128.
// - Bus divider code 0 passes clock; codes 1 to 7 divide 2 to 8.
// - Bus divider codes 8 to 15 divide by 2 through 256 in powers.
// - Status bits 3:2 report active source: internal, external, PLL.
// - Select bits 1:0 choose system clock; code 11 is not available.
// - With monitoring enabled, force internal source on standby/stop return or failure.
// - Source switch takes effect only once the target reports ready; forced fallback to internal does not wait for internal ready.
// - External oscillator is gated into the clock network only once ready.
// - External failure while in use switches to internal, stops external and PLL.
`ifndef CLOCK_SOURCE_CONTROL_CONFIG_REGS_VH
`define CLOCK_SOURCE_CONTROL_CONFIG_REGS_VH
`define OFS_CONTROL        4'h0
`define OFS_CONFIG         4'h4
`define OFS_FAILURE        4'h8
`define CTL_PLL_LOCK       25
`define CTL_PLL_EN         24
`define CTL_MON_EN         19
`define CTL_EXT_BYP        18
`define CTL_EXT_RDY        17
`define CTL_EXT_EN         16
`define CTL_CAL_HI         15
`define CTL_CAL_LO         8
`define CTL_TRIM_HI        7
`define CTL_TRIM_LO        3
`define CTL_INT_RDY        1
`define CTL_INT_EN         0
`define CFG_OUT_HI         26
`define CFG_OUT_LO         24
`define CFG_PLL_SRC        16
`define CFG_CONV_HI        15
`define CFG_CONV_LO        11
`define CFG_BUS_HI         7
`define CFG_BUS_LO         4
`define CFG_STS_HI         3
`define CFG_STS_LO         2
`define CFG_SEL_HI         1
`define CFG_SEL_LO         0
`define FAIL_FLAG          0
`define TRIM_RESET         5'h10
`define SRC_INTERNAL       2'h0
`define SRC_EXTERNAL       2'h1
`define SRC_PLL            2'h2
`define SRC_NONE           2'h3
`endif

//--- hdl/clock_source_control_config.v
// Clock source control and configuration core with an Avalon-MM register slave
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`include "clock_source_control_config_regs.vh"

module clock_source_control_config #(
  parameter CAL_WIDTH = 8
) (
  input  wire                 clk,
  input  wire                 rst_b,
  input  wire [3:0]           address,
  input  wire                 read,
  input  wire                 write,
  input  wire [31:0]          writedata,
  input  wire [3:0]           byteenable,
  output reg  [31:0]          readdata,
  output wire                 waitrequest,
  input  wire                 int_osc_stable,
  input  wire                 ext_osc_stable,
  input  wire                 pll_locked,
  input  wire                 ext_osc_abnormal,
  input  wire [CAL_WIDTH-1:0] factory_cal_in,
  input  wire                 standby_entry,
  input  wire                 standby_exit,
  input  wire                 stop_exit,
  output reg                  internal_osc_enable,
  output reg                  external_osc_enable,
  output reg                  external_osc_bypass,
  output reg                  pll_enable,
  output reg                  pll_input_select,
  output reg  [CAL_WIDTH-1:0] internal_osc_tune,
  output reg  [1:0]           system_clock_mux,
  output reg                  ext_osc_gate,
  output reg                  monitor_active,
  output reg                  clock_failure_flag,
  output wire                 nmi_request,
  output reg  [2:0]           clock_output_select,
  output reg  [7:0]           converter_divisor,
  output reg  [8:0]           bus_divisor
);

  // Register storage
  reg                 clock_monitor_enable;
  reg [CAL_WIDTH-1:0] internal_osc_factory_cal;
  reg                 cal_loaded;
  reg [4:0]           internal_osc_trim;
  reg [4:0]           converter_clock_divider;
  reg [3:0]           bus_clock_divider;
  reg [1:0]           system_clock_source_select;
  reg [1:0]           system_clock_source_status;
  // Bus answer flag
  reg                 ack;

  // Detector levels: 0 internal, 1 external, 2 pll lock, 3 abnormal
  localparam [3:0] DET_RESET = 4'h1;
  wire [3:0] det_raw;
  wire [3:0] det_level;
  wire       internal_osc_ready;
  wire       external_osc_ready;
  wire       pll_lock_flag;
  wire       ext_abnormal;

  // Decode and fallback terms
  wire [31:0] control_word;
  wire [31:0] config_word;
  wire [31:0] wmask;
  wire        wr_ctl;
  wire        wr_cfg;
  wire        wr_fail;
  wire        ext_in_use;
  wire        failure_event;
  wire        force_internal;
  wire        hw_fallback;
  wire [4:0]  conv_code;
  wire        target_ready;

  // Bus handshake: one wait cycle, answer on the second edge
  assign waitrequest = (read | write) & ~ack;
  assign wmask   = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  // Write strobes, first edge of a request only
  assign wr_ctl  = write & ~ack & (address == `OFS_CONTROL);
  assign wr_cfg  = write & ~ack & (address == `OFS_CONFIG);
  assign wr_fail = write & ~ack & (address == `OFS_FAILURE);

  // Readback images, reserved bits zero
  assign control_word = {6'h00, pll_lock_flag, pll_enable, 4'h0, clock_monitor_enable,
                         external_osc_bypass, external_osc_ready, external_osc_enable,
                         internal_osc_factory_cal, internal_osc_trim, 1'b0,
                         internal_osc_ready, internal_osc_enable};

  // Configuration image, reserved bits zero
  assign config_word  = {5'h00, clock_output_select, 7'h00, pll_input_select,
                         converter_clock_divider, 3'h0, bus_clock_divider,
                         system_clock_source_status, system_clock_source_select};

  // Failure handling terms
  assign ext_in_use     = (system_clock_source_status == `SRC_EXTERNAL) |
                          ((system_clock_source_status == `SRC_PLL) & pll_input_select);
  assign failure_event  = monitor_active & ext_abnormal;
  assign force_internal = clock_monitor_enable & (standby_exit | stop_exit);
  assign nmi_request    = clock_failure_flag;

  // Fallback when a failing external oscillator feeds the system clock
  assign hw_fallback    = failure_event & ext_in_use;

  // Detector inputs and the ready flags they yield
  assign det_raw            = {ext_osc_abnormal, pll_locked, ext_osc_stable, int_osc_stable};
  assign internal_osc_ready = det_level[0];
  assign external_osc_ready = det_level[1];
  assign pll_lock_flag      = det_level[2];
  assign ext_abnormal       = det_level[3];

  // Three synchronizer flip-flops and a level flip-flop per detector; a change counts when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_det
      reg [2:0] sync;
      reg       level;
      always @(posedge clk or negedge rst_b) begin
        // Reset to the idle level of each detector
        if (!rst_b) begin
          sync  <= {3{DET_RESET[gi]}};
          level <= DET_RESET[gi];
        end else begin
          sync <= {sync[1:0], det_raw[gi]};
          if (sync[2] == sync[1])
            level <= sync[2];
        end
      end
      assign det_level[gi] = level;
    end
  endgenerate

  // Monitor and oscillator gating follow the ready flag
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      monitor_active <= 1'b0;
      ext_osc_gate   <= 1'b0;
    end else begin
      monitor_active <= clock_monitor_enable & external_osc_ready;
      ext_osc_gate   <= external_osc_ready & external_osc_enable;
    end
  end

  // Factory calibration captured once after reset release
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      internal_osc_factory_cal <= {CAL_WIDTH{1'b0}};
      cal_loaded               <= 1'b0;
    end else if (!cal_loaded) begin
      internal_osc_factory_cal <= factory_cal_in;
      cal_loaded               <= 1'b1;
    end
  end

  // Control register
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      internal_osc_enable  <= 1'b1;
      external_osc_enable  <= 1'b0;
      external_osc_bypass  <= 1'b0;
      pll_enable           <= 1'b0;
      clock_monitor_enable <= 1'b0;
      internal_osc_trim    <= `TRIM_RESET;
    end else begin
      // Software write, each field gated by the byte enable of its lane
      if (wr_ctl) begin
        // Oscillator enables
        if (wmask[`CTL_INT_EN])
          internal_osc_enable <= writedata[`CTL_INT_EN];
        if (wmask[`CTL_EXT_EN])
          external_osc_enable <= writedata[`CTL_EXT_EN];
        // Bypass frozen while the external oscillator runs
        if (wmask[`CTL_EXT_BYP] && !external_osc_enable)
          external_osc_bypass <= writedata[`CTL_EXT_BYP];
        // Monitor and PLL enables
        if (wmask[`CTL_MON_EN])
          clock_monitor_enable <= writedata[`CTL_MON_EN];
        if (wmask[`CTL_PLL_EN])
          pll_enable <= writedata[`CTL_PLL_EN];
        // Trim, applied on top of calibration
        if (wmask[`CTL_TRIM_LO])
          internal_osc_trim <= writedata[`CTL_TRIM_HI:`CTL_TRIM_LO];
      end

      // Hardware actions take precedence over software
      if (standby_entry) begin
        external_osc_enable <= 1'b0;
        pll_enable          <= 1'b0;
      end
      if (standby_exit)
        internal_osc_enable <= 1'b1;
      // Monitored failure of the feeding oscillator
      if (hw_fallback) begin
        internal_osc_enable <= 1'b1;
        external_osc_enable <= 1'b0;
        pll_enable          <= 1'b0;
      end
    end
  end

  // Configuration register
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clock_output_select     <= 3'h0;
      pll_input_select        <= 1'b0;
      converter_clock_divider <= 5'h00;
      bus_clock_divider       <= 4'h0;
      system_clock_source_select    <= `SRC_INTERNAL;
    end else begin
      if (wr_cfg) begin
        // Clock output and PLL input; PLL input frozen while the PLL runs
        if (wmask[`CFG_OUT_LO])
          clock_output_select <= writedata[`CFG_OUT_HI:`CFG_OUT_LO];
        if (wmask[`CFG_PLL_SRC] && !pll_enable)
          pll_input_select <= writedata[`CFG_PLL_SRC];
        // Divider fields
        if (wmask[`CFG_CONV_LO])
          converter_clock_divider <= writedata[`CFG_CONV_HI:`CFG_CONV_LO];
        if (wmask[`CFG_BUS_LO])
          bus_clock_divider <= writedata[`CFG_BUS_HI:`CFG_BUS_LO];
        // System clock request; code 3 refused
        if (wmask[`CFG_SEL_LO] && writedata[`CFG_SEL_HI:`CFG_SEL_LO] != `SRC_NONE)
          system_clock_source_select <= writedata[`CFG_SEL_HI:`CFG_SEL_LO];
      end

      // Fallback overrides any software request
      if (force_internal || hw_fallback)
        system_clock_source_select <= `SRC_INTERNAL;
    end
  end

  // Readiness of the requested source
  assign target_ready = (system_clock_source_select == `SRC_INTERNAL) ? internal_osc_ready :
                        (system_clock_source_select == `SRC_EXTERNAL) ? ext_osc_gate :
                        (system_clock_source_select == `SRC_PLL)      ? pll_lock_flag : 1'b0;

  // Active source follows the request once the target is ready
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      system_clock_source_status <= `SRC_INTERNAL;
      system_clock_mux     <= `SRC_INTERNAL;
    end else if (force_internal || hw_fallback) begin
      system_clock_source_status <= `SRC_INTERNAL;
      system_clock_mux     <= `SRC_INTERNAL;
    end else if (target_ready && system_clock_source_select != system_clock_source_status) begin
      system_clock_source_status <= system_clock_source_select;
      system_clock_mux     <= system_clock_source_select;
    end
  end

  // Failure flag: set wins over software clear
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      clock_failure_flag <= 1'b0;
    else if (failure_event)
      clock_failure_flag <= 1'b1;
    else if (wr_fail && wmask[`FAIL_FLAG] && writedata[`FAIL_FLAG])
      clock_failure_flag <= 1'b0;
  end

  // Converter code reordered as bits 13:11 then 15:14
  assign conv_code = {converter_clock_divider[2:0], converter_clock_divider[4:3]};

  // Divisor decode, registered
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      converter_divisor <= 8'h02;
      bus_divisor       <= 9'h001;
      internal_osc_tune <= {CAL_WIDTH{1'b0}};
    end else begin
      // Converter divisor; codes with bit two set follow a table
      if (!conv_code[2])
        converter_divisor <= {4'h0, conv_code[4:3], 1'b0} + 8'h02;
      else begin
        case ({conv_code[1:0], conv_code[4:3]})
          4'h0:    converter_divisor <= 8'h04;
          4'h1:    converter_divisor <= 8'h08;
          4'h2:    converter_divisor <= 8'h0c;
          4'h3:    converter_divisor <= 8'h10;
          4'h4:    converter_divisor <= 8'h10;
          4'h5:    converter_divisor <= 8'h10;
          4'h6:    converter_divisor <= 8'h18;
          4'h7:    converter_divisor <= 8'h20;
          4'h8:    converter_divisor <= 8'h20;
          4'h9:    converter_divisor <= 8'h20;
          4'ha:    converter_divisor <= 8'h30;
          4'hb:    converter_divisor <= 8'h30;
          4'hc:    converter_divisor <= 8'h40;
          4'hd:    converter_divisor <= 8'h40;
          4'he:    converter_divisor <= 8'h40;
          4'hf:    converter_divisor <= 8'h80;
          default: converter_divisor <= 8'h02;
        endcase
      end

      // Bus divisor: linear codes, then powers of two
      case (bus_clock_divider)
        4'h0:    bus_divisor <= 9'h001;
        4'h1:    bus_divisor <= 9'h002;
        4'h2:    bus_divisor <= 9'h003;
        4'h3:    bus_divisor <= 9'h004;
        4'h4:    bus_divisor <= 9'h005;
        4'h5:    bus_divisor <= 9'h006;
        4'h6:    bus_divisor <= 9'h007;
        4'h7:    bus_divisor <= 9'h008;
        4'h8:    bus_divisor <= 9'h002;
        4'h9:    bus_divisor <= 9'h004;
        4'ha:    bus_divisor <= 9'h008;
        4'hb:    bus_divisor <= 9'h010;
        4'hc:    bus_divisor <= 9'h020;
        4'hd:    bus_divisor <= 9'h040;
        4'he:    bus_divisor <= 9'h080;
        4'hf:    bus_divisor <= 9'h100;
        default: bus_divisor <= 9'h001;
      endcase

      // Oscillator tune from calibration and trim
      internal_osc_tune <= internal_osc_factory_cal + {{(CAL_WIDTH-5){1'b0}}, internal_osc_trim}
                           - {{(CAL_WIDTH-5){1'b0}}, `TRIM_RESET};
    end
  end

  // Read data and answer cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack      <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      // Answer flag, high for the single answer cycle
      ack <= (read | write) & ~ack;
      // Image captured at the first edge of a request, one edge before it is taken
      if (read && !ack) begin
        case (address)
          `OFS_CONTROL: readdata <= control_word;
          `OFS_CONFIG:  readdata <= config_word;
          `OFS_FAILURE: readdata <= {31'h0000_0000, clock_failure_flag};
          default:      readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // clock_source_control_config

//--- tb/clock_source_control_config_chk.sv
// Port-level assertion checker for the clock source control block
`timescale 1ns/10ps
module clock_source_control_config_chk (
  input wire       clk,
  input wire       rst_b,
  input wire       read,
  input wire       write,
  input wire       waitrequest,
  input wire       ext_osc_stable,
  input wire       pll_locked,
  input wire       ext_osc_abnormal,
  input wire       standby_entry,
  input wire       standby_exit,
  input wire       internal_osc_enable,
  input wire       external_osc_enable,
  input wire       external_osc_bypass,
  input wire       pll_enable,
  input wire       pll_input_select,
  input wire [1:0] system_clock_mux,
  input wire       ext_osc_gate,
  input wire       monitor_active,
  input wire       clock_failure_flag,
  input wire       nmi_request
);
  // One clock domain, reset disables everything
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Bus handshake, exactly one wait cycle
  bus_wait_once_a: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("bus request not answered after one wait cycle");
  nmi_follows_flag_a: assert property (nmi_request == clock_failure_flag)
    else $error("nmi request differs from failure flag");
  failure_sets_flag_a: assert property ((monitor_active && ext_osc_abnormal) [*8] |-> clock_failure_flag)
    else $error("abnormal oscillator did not set failure flag");
  failure_fallback_a: assert property ($rose(clock_failure_flag) && ($past(system_clock_mux) == 2'h1 ||
    ($past(system_clock_mux) == 2'h2 && $past(pll_input_select))) |-> ##[0:2] (system_clock_mux == 2'h0 &&
    !pll_enable && !external_osc_enable && internal_osc_enable)) else $error("failure did not fall back to internal");
  ext_gate_ready_a: assert property ($rose(ext_osc_gate) |-> $past(ext_osc_stable, 3) && $past(external_osc_enable))
    else $error("external clock gated before ready");
  switch_ext_ready_a: assert property ($changed(system_clock_mux) && system_clock_mux == 2'h1 |-> $past(ext_osc_gate))
    else $error("switch to external before ready");
  switch_pll_lock_a: assert property ($changed(system_clock_mux) && system_clock_mux == 2'h2 |-> $past(pll_locked, 3))
    else $error("switch to pll before lock");
  standby_stops_a: assert property (standby_entry |=> !external_osc_enable && !pll_enable)
    else $error("standby entry left external or pll enabled");
  standby_wakes_a: assert property (standby_exit |=> internal_osc_enable)
    else $error("standby exit did not enable internal oscillator");
  bypass_hold_a: assert property (external_osc_enable && $past(external_osc_enable) |-> $stable(external_osc_bypass))
    else $error("bypass changed while external enabled");
  pll_src_hold_a: assert property (pll_enable && $past(pll_enable) |-> $stable(pll_input_select))
    else $error("pll input changed while pll enabled");
endmodule // clock_source_control_config_chk

//--- tb/clock_source_control_config_tb.sv
// Self-checking testbench for the clock source control block
`timescale 1ns/10ps
module clock_source_control_config_tb;
  logic        clk, rst_b, read, write, int_osc_stable, ext_osc_stable, pll_locked, ext_osc_abnormal;
  logic        standby_entry, standby_exit, stop_exit, internal_osc_enable, external_osc_enable;
  logic        external_osc_bypass, pll_enable, pll_input_select, ext_osc_gate, monitor_active;
  logic        clock_failure_flag, nmi_request, waitrequest;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, w;
  logic [7:0]  factory_cal_in, internal_osc_tune, converter_divisor, cal;
  logic [8:0]  bus_divisor;
  logic [1:0]  system_clock_mux;
  logic [2:0]  clock_output_select;
  logic [4:0]  c;
  logic [7:0]  conv_tbl [16] = '{4, 8, 12, 16, 16, 16, 24, 32, 32, 32, 48, 48, 64, 64, 64, 128};
  logic [31:0] exp_q [$];
  integer      seed = 19;
  int          n_errors = 0;
  int          samples_checked = 0;

  clock_source_control_config u_clock_source_control_config (.clk, .rst_b, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .int_osc_stable, .ext_osc_stable, .pll_locked, .ext_osc_abnormal,
    .factory_cal_in, .standby_entry, .standby_exit, .stop_exit, .internal_osc_enable, .external_osc_enable,
    .external_osc_bypass, .pll_enable, .pll_input_select, .internal_osc_tune, .system_clock_mux, .ext_osc_gate,
    .monitor_active, .clock_failure_flag, .nmi_request, .clock_output_select, .converter_divisor, .bus_divisor);

  // Clock source
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done();
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus access; a read notes its expected word
  task automatic bus(input bit rd, input [3:0] a, input [31:0] d);
    int n;
    n = 0;
    if (rd)
      exp_q.push_back(d);
    address <= a;
    writedata <= d;
    byteenable <= 4'hf;
    read <= rd;
    write <= !rd;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      test_done();
    end
    @(posedge clk);
  endtask

  // Read data watcher, oldest note first
  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0)
      check(readdata, exp_q.size() ? exp_q.pop_front() : ~readdata);
  end

  // Main sequence
  initial begin
    {rst_b, read, write, ext_osc_stable, pll_locked, ext_osc_abnormal} = '0;
    {standby_entry, standby_exit, stop_exit, address, writedata, byteenable} = '0;
    int_osc_stable = 1'b1;
    factory_cal_in = $random(seed);
    cal = factory_cal_in;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1, 4'h0, {16'h0, cal, 8'h83});
    check(internal_osc_tune, cal);
    bus(1, 4'h4, 32'h0);
    bus(0, 4'hc, 32'hffff_ffff);
    bus(1, 4'hc, 32'h0);
    // Every bus divider code with random converter codes
    for (int i = 0; i < 16; i++) begin
      c = $random(seed);
      w = $random(seed) & 32'hffff_fff0;
      w[15:11] = {c[1:0], c[4:2]};
      w[7:4] = i[3:0];
      bus(0, 4'h4, w);
      bus(1, 4'h4, w & 32'h0701_f8f0);
      check(bus_divisor, i == 0 ? 1 : (i < 8 ? i + 1 : 2 << (i - 8)));
      check(converter_divisor, c[2] ? conv_tbl[{c[1:0], c[4:3]}] : {c[4:3], 1'b0} + 2);
      check(clock_output_select, w[26:24]);
      check(pll_input_select, w[16]);
    end
    bus(0, 4'h4, 32'h0);
    bus(0, 4'h0, 32'hffff_ffff);
    bus(1, 4'h0, {16'h010d, cal, 8'hfb});
    check(internal_osc_tune, {24'h0, cal + 8'h0f});
    bus(0, 4'h4, 32'h0001_0000);
    bus(1, 4'h4, 32'h0);
    bus(0, 4'h0, 32'h81);
    bus(1, 4'h0, {16'h0004, cal, 8'h83});
    bus(0, 4'h0, 32'h81);
    // External then pll as system clock, then a failure
    bus(0, 4'h4, 32'h0001_0001);
    bus(0, 4'h0, 32'h0109_0080);
    bus(1, 4'h4, 32'h0001_0001);
    check(system_clock_mux, 2'h0);
    ext_osc_stable <= 1'b1;
    pll_locked <= 1'b1;
    repeat (10) @(posedge clk);
    check(monitor_active, 1'b1);
    check(system_clock_mux, 2'h1);
    bus(1, 4'h0, {16'h030b, cal, 8'h82});
    bus(0, 4'h4, 32'h0001_0002);
    repeat (4) @(posedge clk);
    check(system_clock_mux, 2'h2);
    bus(0, 4'h4, 32'h0001_0003);
    bus(1, 4'h4, 32'h0001_000a);
    ext_osc_abnormal <= 1'b1;
    repeat (10) @(posedge clk);
    check({clock_failure_flag, nmi_request, system_clock_mux}, 4'hc);
    check({external_osc_enable, pll_enable, internal_osc_enable}, 3'h1);
    {ext_osc_abnormal, ext_osc_stable, pll_locked} <= 3'h0;
    repeat (8) @(posedge clk);
    check(monitor_active, 1'b0);
    bus(1, 4'h8, 32'h1);
    bus(1, 4'h0, {16'h0008, cal, 8'h83});
    bus(1, 4'h4, 32'h0001_0000);
    bus(0, 4'h8, 32'h1);
    bus(1, 4'h8, 32'h0);
    // Stop exit with monitoring forces the internal source
    bus(0, 4'h0, 32'h0109_0081);
    ext_osc_stable <= 1'b1;
    repeat (8) @(posedge clk);
    bus(0, 4'h4, 32'h0001_0001);
    repeat (4) @(posedge clk);
    check(system_clock_mux, 2'h1);
    stop_exit <= 1'b1;
    @(posedge clk);
    stop_exit <= 1'b0;
    repeat (2) @(posedge clk);
    check(system_clock_mux, 2'h0);
    bus(1, 4'h4, 32'h0001_0000);
    // Standby entry and exit
    standby_entry <= 1'b1;
    @(posedge clk);
    standby_entry <= 1'b0;
    @(posedge clk);
    check({external_osc_enable, pll_enable}, 2'h0);
    bus(0, 4'h0, 32'h80);
    check(internal_osc_enable, 1'b0);
    standby_exit <= 1'b1;
    @(posedge clk);
    standby_exit <= 1'b0;
    @(posedge clk);
    check(internal_osc_enable, 1'b1);
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule // clock_source_control_config_tb

bind clock_source_control_config clock_source_control_config_chk u_chk (.clk, .rst_b, .read, .write, .waitrequest,
  .ext_osc_stable, .pll_locked, .ext_osc_abnormal, .standby_entry, .standby_exit, .internal_osc_enable,
  .external_osc_enable, .external_osc_bypass, .pll_enable, .pll_input_select, .system_clock_mux, .ext_osc_gate,
  .monitor_active, .clock_failure_flag, .nmi_request);
